// file: ivpm_cpu_model.sv
// CPU core model that acknowledges vector requests
`timescale 1ns/100ps
module ivpm_cpu_model
  import ivpm_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // Behaviour control
  input  wire logic                  ack_en,
  input  wire logic [3:0]            ack_delay,
  // Vector request
  input  wire logic                  cpu_irq_req,
  input  wire logic [ivpm_pkg::NUM_W-1:0] cpu_irq_num,
  output logic                       cpu_irq_ack,
  output logic [ivpm_pkg::NUM_W-1:0] last_num
);
  logic [3:0] wait_cnt;
  logic [1:0] gap;
  // =========================================================
  // Acknowledge
  // Gap of three skips the stale request seen just after an ack
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cpu_irq_ack <= 1'b0;
      wait_cnt    <= 4'h0;
      gap         <= 2'h0;
      last_num    <= '0;
    end else begin
      cpu_irq_ack <= 1'b0;
      if (gap != 2'h0) begin
        gap <= gap - 2'h1;
      end else if (ack_en && cpu_irq_req) begin
        if (wait_cnt >= ack_delay) begin
          cpu_irq_ack <= 1'b1;
          last_num    <= cpu_irq_num;
          wait_cnt    <= 4'h0;
          gap         <= 2'h3;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end else begin
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule : ivpm_cpu_model

// file: ivpm_flag_cell.sv
// One sticky pending flag with set-over-clear priority
`timescale 1ns/100ps
module ivpm_flag_cell #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Control
  input  wire logic set,
  input  wire logic clr,
  // State
  output logic      flag
);

  // Set wins so an event on the clearing cycle is kept
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flag <= RST_VAL;
    end else begin
      flag <= set | (flag & ~clr);
    end
  end

endmodule : ivpm_flag_cell

// file: ivpm_pkg.sv
// Constants shared by the interrupt vector and priority map
package ivpm_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_IRQ   = 32;
  localparam int NUM_W     = 5;
  localparam int PRIO_W    = 5;
  localparam int SLOT_BITS = 3;
  localparam int PAGE_LSB  = 8;
  localparam int PAGE_W    = 32 - PAGE_LSB;
  localparam int SEL_W     = 2;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_PAGE_PRI = 8'h00;
  localparam logic [7:0] OFF_PAGE_SEC = 8'h04;
  localparam logic [7:0] OFF_FLAG     = 8'h08;
  localparam logic [7:0] OFF_CLEAR    = 8'h0C;
  localparam logic [7:0] OFF_ENABLE   = 8'h10;
  localparam logic [7:0] OFF_TRAP     = 8'h14;
  localparam logic [7:0] OFF_CONFIG   = 8'h18;
  localparam logic [7:0] OFF_STATUS   = 8'h1C;
  localparam logic [7:0] OFF_VECTOR   = 8'h20;

  // ==========================================================
  // Reset values and fixed masks
  localparam logic [PAGE_W-1:0]  PAGE_RST   = 24'h000000;
  localparam logic [31:0]        FLAG_RST   = 32'h00000001;
  localparam logic [31:0]        ENABLE_RST = 32'h00000000;
  localparam logic [31:0]        FORCED_EN  = 32'h00000003;
  localparam logic [SEL_W-1:0]   SEL_RST    = 2'h0;

  // ==========================================================
  // Interrupt numbers
  localparam logic [NUM_W-1:0] IRQ_RESET  = 5'h00;
  localparam logic [NUM_W-1:0] IRQ_NMI    = 5'h01;
  localparam logic [NUM_W-1:0] IRQ_EXT0   = 5'h02;
  localparam logic [NUM_W-1:0] IRQ_EXT1   = 5'h03;
  localparam logic [NUM_W-1:0] IRQ_SEL_TX = 5'h05;
  localparam logic [NUM_W-1:0] IRQ_SEL_RX = 5'h07;
  localparam logic [NUM_W-1:0] IRQ_RTC    = 5'h12;
  localparam logic [NUM_W-1:0] IRQ_OS     = 5'h1A;
  localparam logic [NUM_W-1:0] SEC_LO     = 5'h10;
  localparam logic [NUM_W-1:0] SEC_HI     = 5'h17;

  // Serial port zero select codes
  localparam logic [SEL_W-1:0] SEL_CARD  = 2'h0;
  localparam logic [SEL_W-1:0] SEL_AUDIO = 2'h1;

  // Fixed priority per interrupt number, smaller wins
  localparam logic [PRIO_W-1:0] PRIO_TABLE [NUM_IRQ] = '{
    5'h00, 5'h01, 5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A,
    5'h0B, 5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h12, 5'h15, 5'h16,
    5'h04, 5'h08, 5'h0C, 5'h10, 5'h13, 5'h14, 5'h17, 5'h18,
    5'h02, 5'h19, 5'h1A, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12};

endpackage : ivpm_pkg

// file: ivpm_prio_select.sv
// Fixed priority selection over the active interrupts
`timescale 1ns/100ps
module ivpm_prio_select
  import ivpm_pkg::*;
#(
  parameter int N = ivpm_pkg::NUM_IRQ
) (
  // Candidates
  input  wire logic [N-1:0]              active,
  // Winner
  output logic [ivpm_pkg::NUM_W-1:0]     best_num,
  output logic                           best_valid
);

  logic [PRIO_W-1:0] best_prio;

  // Strict compare: equal priorities go to the lower number
  always_comb begin
    best_num   = '0;
    best_valid = 1'b0;
    best_prio  = '1;
    for (int i = 0; i < N; i++) begin
      if (active[i] && (!best_valid || PRIO_TABLE[i] < best_prio)) begin
        best_num   = NUM_W'(i);
        best_prio  = PRIO_TABLE[i];
        best_valid = 1'b1;
      end
    end
  end

endmodule : ivpm_prio_select

// file: ivpm_top.sv
// Interrupt vector and priority map with APB register access
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/100ps

// Functional notes
// - Hardware or software reset takes trap zero at relative byte 0 with priority 0, the highest.
// - The non-maskable request is tied inactive inside, its slot at byte 8 priority 1 reached only by trap one.
// - Interrupts 0 to 15 and 24 to 31 take their absolute vector from the primary page pointer.
// - Interrupts 16 to 23 take their absolute vector from the secondary page pointer.
// - External user interrupt zero is trap two at byte 10h with priority 3.
// - External user interrupt one is trap three at byte 18h with priority 5.
// - The selectable transmit interrupt serves serial audio or card transmit, at byte 28h priority 7.
// - The selectable receive interrupt serves serial audio or card SDIO receive, at byte 38h priority 10.
// - The wakeup or clock interrupt is trap eighteen at byte 90h with priority 12.
// - The realtime OS interrupt is trap twenty-six at byte D0h with priority 26, the lowest.
// - Every interrupt has a fixed relative location and priority, slots eight bytes apart by number.
// - Select code 00b routes card SDIO to the receive slot and code 01 routes serial audio receive.
// - Writing ones to the flag register clears the matching pending flags.
module ivpm_top
  import ivpm_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Interrupt sources
  input  wire logic                     ext_user_irq_zero,
  input  wire logic                     ext_user_irq_one,
  input  wire logic                     audio_tx_irq,
  input  wire logic                     card_tx_irq,
  input  wire logic                     audio_rx_irq,
  input  wire logic                     card_sdio_irq,
  input  wire logic [31:0]              periph_irq,
  // CPU vector fetch
  output logic                          cpu_irq_req,
  output logic [ivpm_pkg::NUM_W-1:0]    cpu_irq_num,
  output logic [31:0]                   cpu_vector_addr,
  input  wire logic                     cpu_irq_ack,
  // Interrupt line
  output logic                          irq_out
);

  // ========================================================
  // State
  logic [PAGE_W-1:0]  vector_page_primary;
  logic [PAGE_W-1:0]  vector_page_secondary;
  logic [31:0]        irq_enable_reg_zero;
  logic [SEL_W-1:0]   serial_port_zero_select;
  logic [31:0]        irq_flag_reg_zero;
  logic               ack_block;

  // ========================================================
  // APB decode
  wire                setup_ph   = psel & ~penable;
  wire                access_ph  = psel & penable & pready;
  wire                wr_en      = access_ph & pwrite;
  wire                hit_pri    = (paddr == OFF_PAGE_PRI);
  wire                hit_sec    = (paddr == OFF_PAGE_SEC);
  wire                hit_flag   = (paddr == OFF_FLAG);
  wire                hit_clear  = (paddr == OFF_CLEAR);
  wire                hit_enable = (paddr == OFF_ENABLE);
  wire                hit_trap   = (paddr == OFF_TRAP);
  wire                hit_config = (paddr == OFF_CONFIG);
  wire                hit_status = (paddr == OFF_STATUS);
  wire                hit_vector = (paddr == OFF_VECTOR);
  wire                mapped     = hit_pri | hit_sec | hit_flag | hit_clear
                                 | hit_enable | hit_trap | hit_config
                                 | hit_status | hit_vector;
  wire                trap_wr    = wr_en & hit_trap;
  // Flag and clear offsets both act as write-one-to-clear
  wire                clr_wr     = wr_en & (hit_flag | hit_clear);

  // ========================================================
  // Source routing
  wire sel_tx = (serial_port_zero_select == SEL_CARD)  ? card_tx_irq :
                (serial_port_zero_select == SEL_AUDIO) ? audio_tx_irq :
                1'b0;
  wire sel_rx = (serial_port_zero_select == SEL_CARD)  ? card_sdio_irq :
                (serial_port_zero_select == SEL_AUDIO) ? audio_rx_irq :
                1'b0;

  // Slot 0 comes only from reset or trap zero; slot 1 has no pin
  wire [31:0] hw_set = {periph_irq[31:8], sel_rx, periph_irq[6], sel_tx,
                        periph_irq[4], ext_user_irq_one, ext_user_irq_zero,
                        1'b0, 1'b0};
  wire [31:0] trap_set = trap_wr ? (32'h00000001 << pwdata[NUM_W-1:0])
                                 : 32'h00000000;
  wire [31:0] set_vec  = hw_set | trap_set;

  // Ack clears the vector being fetched; a repeat next cycle is stale
  wire        ack_ok   = cpu_irq_ack & cpu_irq_req & ~ack_block;
  wire [31:0] ack_clr  = ack_ok ? (32'h00000001 << cpu_irq_num)
                                : 32'h00000000;
  wire [31:0] w1c_clr  = clr_wr ? pwdata : 32'h00000000;
  wire [31:0] clr_vec  = w1c_clr | ack_clr;

  // ========================================================
  // Pending flags
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_flag
      ivpm_flag_cell #(
        .RST_VAL (FLAG_RST[g])
      ) u_cell (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .set     (set_vec[g]),
        .clr     (clr_vec[g]),
        .flag    (irq_flag_reg_zero[g])
      );
    end
  endgenerate

  // ========================================================
  // Priority and vector forming
  wire [31:0]       eff_en = irq_enable_reg_zero | FORCED_EN;
  wire [31:0]       active = irq_flag_reg_zero & eff_en;
  logic [NUM_W-1:0] best_num;
  logic             best_valid;

  ivpm_prio_select #(
    .N          (NUM_IRQ)
  ) u_select (
    .active     (active),
    .best_num   (best_num),
    .best_valid (best_valid)
  );

  wire              use_sec   = (best_num >= SEC_LO) && (best_num <= SEC_HI);
  wire [PAGE_W-1:0] page_sel  = use_sec ? vector_page_secondary
                                        : vector_page_primary;
  wire [31:0]       next_addr = {page_sel, best_num, {SLOT_BITS{1'b0}}};

  // ========================================================
  // Read mux
  wire [31:0] status_word = {cpu_irq_req, {(31-NUM_W){1'b0}}, cpu_irq_num};
  wire [31:0] rd_word =
      hit_pri    ? {vector_page_primary, {PAGE_LSB{1'b0}}} :
      hit_sec    ? {vector_page_secondary, {PAGE_LSB{1'b0}}} :
      hit_flag   ? irq_flag_reg_zero :
      hit_enable ? irq_enable_reg_zero :
      hit_config ? {{(32-SEL_W){1'b0}}, serial_port_zero_select} :
      hit_status ? status_word :
      hit_vector ? cpu_vector_addr :
      32'h00000000;

  // ========================================================
  // APB response: one wait-free access cycle after setup
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      prdata  <= (setup_ph & ~pwrite) ? rd_word : 32'h00000000;
    end
  end

  // ========================================================
  // Writable registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vector_page_primary     <= PAGE_RST;
      vector_page_secondary   <= PAGE_RST;
      irq_enable_reg_zero     <= ENABLE_RST;
      serial_port_zero_select <= SEL_RST;
    end else if (wr_en) begin
      if (hit_pri) begin
        vector_page_primary <= pwdata[31:PAGE_LSB];
      end
      if (hit_sec) begin
        vector_page_secondary <= pwdata[31:PAGE_LSB];
      end
      if (hit_enable) begin
        irq_enable_reg_zero <= pwdata;
      end
      if (hit_config) begin
        serial_port_zero_select <= pwdata[SEL_W-1:0];
      end
    end
  end

  // ========================================================
  // CPU side outputs, registered
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cpu_irq_req     <= 1'b0;
      cpu_irq_num     <= IRQ_RESET;
      cpu_vector_addr <= 32'h00000000;
      irq_out         <= 1'b0;
      ack_block       <= 1'b0;
    end else begin
      cpu_irq_req     <= best_valid;
      cpu_irq_num     <= best_num;
      cpu_vector_addr <= next_addr;
      irq_out         <= |active;
      ack_block       <= ack_ok;
    end
  end

  // ========================================================
  // Checks
  a_reset_vector: assert property (@(posedge mclk)
    $fell(sys_rst) |-> ##[0:2] (cpu_irq_req && cpu_irq_num == 5'h00
      && cpu_vector_addr[7:0] == 8'h00))
    else $error("reset vector not presented");

  a_nmi_trap_only: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(irq_flag_reg_zero[1]) |->
      $past(trap_wr) && $past(pwdata[NUM_W-1:0]) == 5'h01)
    else $error("slot one set without trap one");

  a_primary_page: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 (cpu_irq_req && (cpu_irq_num < 5'h10 || cpu_irq_num > 5'h17))
    |-> cpu_vector_addr[31:8] == $past(vector_page_primary))
    else $error("primary page not used");

  a_secondary_page: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 (cpu_irq_req && cpu_irq_num >= 5'h10 && cpu_irq_num <= 5'h17)
    |-> cpu_vector_addr[31:8] == $past(vector_page_secondary))
    else $error("secondary page not used");

  a_slot_spacing: assert property (@(posedge mclk) disable iff (sys_rst)
    cpu_irq_req |-> cpu_vector_addr[7:0] == {cpu_irq_num, 3'b000})
    else $error("slot offset wrong");

  a_fixed_slots: assert property (@(posedge mclk) disable iff (sys_rst)
    cpu_irq_req |->
      (cpu_irq_num != IRQ_EXT0   || cpu_vector_addr[7:0] == 8'h10) &&
      (cpu_irq_num != IRQ_EXT1   || cpu_vector_addr[7:0] == 8'h18) &&
      (cpu_irq_num != IRQ_SEL_TX || cpu_vector_addr[7:0] == 8'h28) &&
      (cpu_irq_num != IRQ_SEL_RX || cpu_vector_addr[7:0] == 8'h38) &&
      (cpu_irq_num != IRQ_RTC    || cpu_vector_addr[7:0] == 8'h90) &&
      (cpu_irq_num != IRQ_OS     || cpu_vector_addr[7:0] == 8'hD0))
    else $error("named slot at wrong location");

  a_ext0_source: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(irq_flag_reg_zero[2]) |->
      $past(ext_user_irq_zero) || $past(trap_wr))
    else $error("ext zero flag without cause");

  a_rx_routing: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(irq_flag_reg_zero[7]) && !$past(trap_wr) |->
      $past(serial_port_zero_select == SEL_CARD ? card_sdio_irq :
            serial_port_zero_select == SEL_AUDIO ? audio_rx_irq : 1'b0))
    else $error("receive slot routed wrongly");

  a_write_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    (clr_vec & ~set_vec) != 32'h00000000 |=>
      (irq_flag_reg_zero & $past(clr_vec & ~set_vec)) == 32'h00000000)
    else $error("write one did not clear");

  a_prio_order: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 ($past(active[IRQ_EXT0]) && $past(active[IRQ_EXT1]))
      |-> cpu_irq_num != IRQ_EXT1)
    else $error("lower priority served first");

  // Skips the edge whose output was still held in reset
  a_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)
    !$past(sys_rst) |-> irq_out == $past(|(irq_flag_reg_zero & eff_en)))
    else $error("interrupt line wrong");

  // ========================================================
  // Bus and flag checks
  a_ready_setup: assert property (@(posedge mclk) disable iff (sys_rst)
    setup_ph |=> pready)
    else $error("no ready after setup");

  a_ready_single: assert property (@(posedge mclk) disable iff (sys_rst)
    pready |=> !pready)
    else $error("ready held too long");

  a_error_unmapped: assert property (@(posedge mclk) disable iff (sys_rst)
    pslverr == (pready && !$past(mapped)))
    else $error("slave error mismatch");

  a_enable_write: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_en && hit_enable |=> irq_enable_reg_zero == $past(pwdata))
    else $error("enable write lost");

  a_page_pri_write: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_en && hit_pri |=> vector_page_primary == $past(pwdata[31:PAGE_LSB]))
    else $error("primary page write lost");

  a_page_sec_write: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_en && hit_sec |=> vector_page_secondary == $past(pwdata[31:PAGE_LSB]))
    else $error("secondary page write lost");

  a_flag_reset: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(sys_rst) |-> irq_flag_reg_zero == FLAG_RST)
    else $error("flags wrong after reset");

  a_trap_sets: assert property (@(posedge mclk) disable iff (sys_rst)
    trap_wr |=> irq_flag_reg_zero[$past(pwdata[NUM_W-1:0])])
    else $error("trap did not set its flag");

  a_ack_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    ack_ok && !set_vec[cpu_irq_num] |=> !irq_flag_reg_zero[$past(cpu_irq_num)])
    else $error("acknowledged flag still set");

  a_tx_routing: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(irq_flag_reg_zero[5]) && !$past(trap_wr) |->
      $past(serial_port_zero_select == SEL_CARD ? card_tx_irq :
            serial_port_zero_select == SEL_AUDIO ? audio_tx_irq : 1'b0))
    else $error("transmit slot routed wrongly");

  a_idle_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    !$past(sys_rst) && $past(active) == 32'h00000000 |-> !cpu_irq_req && !irq_out)
    else $error("request without pending interrupt");

  // Winner outranks, or ties below, every slot pending one edge earlier
  genvar p;
  generate
    for (p = 0; p < NUM_IRQ; p++) begin : g_prio_chk
      a_winner_prio: assert property (@(posedge mclk) disable iff (sys_rst)
        cpu_irq_req && !$past(sys_rst) && $past(active[p])
          |-> PRIO_TABLE[cpu_irq_num] <= PRIO_TABLE[p])
        else $error("winner outranked by a pending interrupt");
    end
  endgenerate

  c_reset_fetch: cover property (@(posedge mclk) disable iff (sys_rst)
    cpu_irq_req && cpu_irq_num == IRQ_RESET && cpu_irq_ack);
  c_secondary: cover property (@(posedge mclk) disable iff (sys_rst)
    cpu_irq_req && use_sec);
  c_set_clear: cover property (@(posedge mclk) disable iff (sys_rst)
    (set_vec & clr_vec) != 32'h00000000);
  c_nmi_trap: cover property (@(posedge mclk) disable iff (sys_rst)
    $rose(irq_flag_reg_zero[1]));
  c_ack_taken: cover property (@(posedge mclk) disable iff (sys_rst)
    ack_ok && cpu_irq_num != IRQ_RESET);

endmodule : ivpm_top

// file: testbench.sv
// Self-checking bench for the interrupt vector and priority map
`timescale 1ns/100ps
module testbench;
  import ivpm_pkg::*;
  logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        cpu_irq_req, cpu_irq_ack, irq_out, ack_en, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, periph, cpu_vector_addr, rd;
  logic [5:0]  src;
  logic [4:0]  cpu_irq_num, last_num;
  logic [3:0]  ack_delay;
  int          n_mismatch, comparisons, cycles;
  localparam logic [31:0] PPRI = 32'hA5A5A500;
  localparam logic [31:0] PSEC = 32'h3C3C3C00;
  localparam logic [4:0] VEC [12] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h07, 5'h0F,
                                      5'h10, 5'h12, 5'h17, 5'h18, 5'h1A, 5'h1F};
  localparam logic [4:0] PA [6] = '{5'h12, 5'h03, 5'h19, 5'h18, 5'h02, 5'h05};
  localparam logic [4:0] PB [6] = '{5'h07, 5'h10, 5'h1A, 5'h01, 5'h03, 5'h11};
  localparam logic [4:0] PW [6] = '{5'h07, 5'h10, 5'h19, 5'h01, 5'h02, 5'h05};

  ivpm_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_user_irq_zero(src[0]), .ext_user_irq_one(src[1]),
    .audio_tx_irq(src[2]), .card_tx_irq(src[3]), .audio_rx_irq(src[4]),
    .card_sdio_irq(src[5]), .periph_irq(periph), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_num(cpu_irq_num), .cpu_vector_addr(cpu_vector_addr),
    .cpu_irq_ack(cpu_irq_ack), .irq_out(irq_out));
  ivpm_cpu_model u_cpu (.mclk(mclk), .sys_rst(sys_rst), .ack_en(ack_en),
    .ack_delay(ack_delay), .cpu_irq_req(cpu_irq_req), .cpu_irq_num(cpu_irq_num),
    .cpu_irq_ack(cpu_irq_ack), .last_num(last_num));

  // =========================================================
  // Shared tasks
  task finish_test;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask : rdc
  task pulse(input logic [5:0] s, input logic [31:0] p);
    @(posedge mclk);
    src <= s; periph <= p;
    @(posedge mclk);
    src <= 6'h00; periph <= 32'h0;
  endtask : pulse
  function logic [31:0] vaddr(input logic [4:0] n);
    vaddr = ((n >= 5'd16 && n <= 5'd23) ? PSEC : PPRI) | {24'h0, n, 3'b000};
  endfunction : vaddr
  task expect_vec(input logic [4:0] n);
    repeat (3) @(posedge mclk);
    chk("cpu_irq_req", cpu_irq_req, 1);
    chk("irq_out", irq_out, 1);
    chk("cpu_irq_num", cpu_irq_num, n);
    chk("cpu_vector_addr", cpu_vector_addr, vaddr(n));
    wr(OFF_FLAG, 32'hFFFFFFFF);
  endtask : expect_vec
  task expect_none;
    repeat (3) @(posedge mclk);
    chk("cpu_irq_req", cpu_irq_req, 0);
    wr(OFF_FLAG, 32'hFFFFFFFF);
  endtask : expect_none

  // =========================================================
  // Scenarios
  task t_reset;
    repeat (2) @(posedge mclk);
    chk("cpu_irq_req", cpu_irq_req, 1);
    chk("cpu_irq_num", cpu_irq_num, 0);
    chk("cpu_vector_addr", cpu_vector_addr, 0);
    rdc("page_pri", OFF_PAGE_PRI, 0);
    ack_en <= 1'b1; ack_delay <= 4'h0;
    repeat (8) @(posedge mclk);
    chk("cpu_irq_req", cpu_irq_req, 0);
    ack_en <= 1'b0;
    $display("test reset done");
  endtask : t_reset
  task t_vectors;
    wr(OFF_PAGE_PRI, PPRI); wr(OFF_PAGE_SEC, PSEC); wr(OFF_ENABLE, 32'hFFFFFFFF);
    rdc("page_sec", OFF_PAGE_SEC, PSEC);
    for (int i = 0; i < 12; i++) begin
      wr(OFF_TRAP, {27'h0, VEC[i]});
      expect_vec(VEC[i]);
    end
    wr(OFF_TRAP, 32'h0);
    expect_vec(IRQ_RESET);
    $display("test vectors done");
  endtask : t_vectors
  task t_prio;
    for (int i = 0; i < 6; i++) begin
      wr(OFF_TRAP, {27'h0, PA[i]}); wr(OFF_TRAP, {27'h0, PB[i]});
      expect_vec(PW[i]);
    end
    $display("test priority done");
  endtask : t_prio
  task t_ext;
    pulse(6'h01, 32'h0); expect_vec(IRQ_EXT0);
    pulse(6'h02, 32'h0); expect_vec(IRQ_EXT1);
    pulse(6'h00, 32'h2); expect_none;
    pulse(6'h00, 32'h10); expect_vec(5'h04);
    $display("test sources done");
  endtask : t_ext
  task t_select;
    wr(OFF_CONFIG, 32'h0);
    pulse(6'h10, 32'h0); expect_none;
    pulse(6'h20, 32'h0); expect_vec(IRQ_SEL_RX);
    pulse(6'h08, 32'h0); expect_vec(IRQ_SEL_TX);
    pulse(6'h04, 32'h0); expect_none;
    wr(OFF_CONFIG, 32'h1);
    pulse(6'h20, 32'h0); expect_none;
    pulse(6'h10, 32'h0); expect_vec(IRQ_SEL_RX);
    pulse(6'h04, 32'h0); expect_vec(IRQ_SEL_TX);
    pulse(6'h08, 32'h0); expect_none;
    wr(OFF_CONFIG, 32'h2);
    rdc("config", OFF_CONFIG, 32'h2);
    pulse(6'h3C, 32'h0);
    expect_none;
    wr(OFF_CONFIG, 32'h3);
    pulse(6'h3C, 32'h0);
    expect_none;
    $display("test select done");
  endtask : t_select
  task t_mask;
    wr(OFF_ENABLE, 32'h0); wr(OFF_TRAP, 32'h4);
    repeat (3) @(posedge mclk);
    chk("irq_out", irq_out, 0);
    rdc("flag", OFF_FLAG, 32'h10);
    wr(OFF_ENABLE, 32'h10);
    repeat (3) @(posedge mclk);
    chk("irq_out", irq_out, 1);
    rdc("status", OFF_STATUS, 32'h80000004);
    wr(OFF_CLEAR, 32'h10);
    repeat (3) @(posedge mclk);
    chk("irq_out", irq_out, 0);
    wr(OFF_TRAP, 32'h6); wr(OFF_FLAG, 32'h40);
    rdc("flag", OFF_FLAG, 32'h0);
    rdc("trap", OFF_TRAP, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk("pslverr", er, 1);
    chk("prdata", rd, 0);
    $display("test mask done");
  endtask : t_mask
  task t_ack;
    wr(OFF_ENABLE, 32'hFFFFFFFF);
    ack_en <= 1'b1; ack_delay <= 4'h3;
    wr(OFF_TRAP, 32'h9); wr(OFF_TRAP, 32'hB);
    repeat (3) @(posedge mclk);
    chk("first_ack", last_num, 5'h09);
    repeat (27) @(posedge mclk);
    chk("last_num", last_num, 5'h0B);
    chk("cpu_irq_req", cpu_irq_req, 0);
    $display("test ack done");
  endtask : t_ack

  // =========================================================
  // Clock, timeout and main sequence
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      finish_test;
    end
  end
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; src = 6'h00; periph = 32'h0; ack_en = 1'b0; ack_delay = 4'h0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset; t_vectors; t_prio; t_ext; t_select; t_mask; t_ack;
    finish_test;
  end
endmodule : testbench
